// *** src/pstc_map.svh ***
// offsets, field positions, reset values and timing figures of the sync/slot block
// assumes a 100 MHz clock; times are in ns and turned into cycles by the design
`ifndef PSTC_MAP_SVH
`define PSTC_MAP_SVH
`define PSTC_CLK_NS 10
`define PSTC_BLANK_NS 128000
`define PSTC_SLOT1_NS 51000
`define PSTC_SLOT2_NS 195000
`define PSTC_SLOT3_NS 350000
`define PSTC_ASYNC_NS 228000
`define PSTC_BIT_NS 8000
`define PSTC_DIS_ON_NS 22750
`define PSTC_DIS_OFF_NS 43250
`define PSTC_UART_NS 10000
`define PSTC_INIT_SHORT 6'd22
`define PSTC_INIT_LONG 6'd32
`define PSTC_ADR_CFG0 8'h00
`define PSTC_ADR_CFG1 8'h04
`define PSTC_ADR_STAT 8'h08
`define PSTC_ADR_MEAS 8'h0c
`define PSTC_ADR_OUT 8'h10
`define PSTC_B_ASYNC 0
`define PSTC_B_BUSPAR 1
`define PSTC_B_SLOT 2
`define PSTC_B_V13 4
`define PSTC_B_F16 5
`define PSTC_B_INITEXT 6
`define PSTC_B_INITDIS 7
`define PSTC_B_DISEN 8
`define PSTC_B_PROG 9
`define PSTC_B_ZERO 16
`define PSTC_B_STOP 32
`define PSTC_B_SLOPE 48
`define PSTC_CFG_RST 64'h0004_3fff_0000_0000
`endif

// *** src/pstc_pkg.sv ***
// types of the sync/slot block
// assumes nothing beyond the design file that uses it
package pstc_pkg;
   typedef enum logic {CORD_IDLE, CORD_RUN} pstc_cord_st_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} pstc_rx_st_t;
   typedef struct packed {
      logic valid;
      logic signed [13:0] x;
      logic signed [13:0] y;
   } pstc_sample_t;
   typedef struct packed {
      logic async_mode;
      logic bus_par;
      logic [1:0] slot_sel;
      logic proto_v13;
      logic frame16;
      logic init_ext;
      logic init_dis;
      logic dis_en;
      logic prog_en;
      logic [13:0] zero;
      logic [13:0] stop;
      logic [7:0] slope;
   } pstc_cfg_t;
endpackage

// *** src/pstc_sync_slot.sv ***
// sync trigger, slot timing, frame sender, angle unit and supply-pin programming port
// assumes a wishbone classic master on clk_i and an analogue comparator on sync_cmp_i
// Function
// - blank retriggers 121..135 us after trigger
// - sync mode by trigger, async free-running
// - legacy async sends one slot per period
// - legacy async splits word over two periods
// - universal and parallel bus modes only
// - zero and stop angle map output range
// - serial supply-pin writes program config bits
// - serial reads return magnitude, gain, angle
// - sink current drives high; comparator detects sync
// - rotation unit computes angle and magnitude
// - trigger instant is slot time zero
// - two-bit field picks bus slot
// - init phase sends 22 or 32 blocks
// - optional active discharge of sync pulse
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pstc_map.svh"
module pstc_sync_slot #(
   parameter int unsigned BLANK_CYC = `PSTC_BLANK_NS / `PSTC_CLK_NS,
   parameter int unsigned SLOT1_CYC = `PSTC_SLOT1_NS / `PSTC_CLK_NS,
   parameter int unsigned SLOT2_CYC = `PSTC_SLOT2_NS / `PSTC_CLK_NS,
   parameter int unsigned SLOT3_CYC = `PSTC_SLOT3_NS / `PSTC_CLK_NS,
   parameter int unsigned ASYNC_CYC = `PSTC_ASYNC_NS / `PSTC_CLK_NS,
   parameter int unsigned DIS_OFF_CYC = `PSTC_DIS_OFF_NS / `PSTC_CLK_NS
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // supply pin
   input wire logic sync_cmp_i,
   input wire logic prog_rx_i,
   output logic current_sink_o,
   output logic discharge_o,
   output logic trigger_time_reference_o,
   // sensor path
   input wire pstc_pkg::pstc_sample_t sample_i,
   input wire logic [7:0] gain_control_value_i,
   output logic [11:0] out_code_o
);
   localparam int unsigned HALF_CYC = `PSTC_BIT_NS / `PSTC_CLK_NS / 2;
   localparam int unsigned UART_CYC = `PSTC_UART_NS / `PSTC_CLK_NS;
   localparam int unsigned DIS_ON_CYC = `PSTC_DIS_ON_NS / `PSTC_CLK_NS;

   logic [63:0] cfg_reg, cfg_next;
   pstc_pkg::pstc_cfg_t cfg;
   assign cfg.async_mode = cfg_reg[`PSTC_B_ASYNC];
   assign cfg.bus_par = cfg_reg[`PSTC_B_BUSPAR];
   assign cfg.slot_sel = cfg_reg[`PSTC_B_SLOT +: 2];
   assign cfg.proto_v13 = cfg_reg[`PSTC_B_V13];
   assign cfg.frame16 = cfg_reg[`PSTC_B_F16];
   assign cfg.init_ext = cfg_reg[`PSTC_B_INITEXT];
   assign cfg.init_dis = cfg_reg[`PSTC_B_INITDIS];
   assign cfg.dis_en = cfg_reg[`PSTC_B_DISEN];
   assign cfg.prog_en = cfg_reg[`PSTC_B_PROG];
   assign cfg.zero = cfg_reg[`PSTC_B_ZERO +: 14];
   assign cfg.stop = cfg_reg[`PSTC_B_STOP +: 14];
   assign cfg.slope = cfg_reg[`PSTC_B_SLOPE +: 8];

   // ----------------------------------------
   // sync detection and blanking
   // ----------------------------------------
   logic s1_reg, s2_reg, s3_reg, trig, trig_reg;
   logic [15:0] blank_reg, blank_next;
   logic [7:0] trig_cnt_reg, trig_cnt_next;
   always_comb begin
      trig = s2_reg & ~s3_reg & (blank_reg == 16'h0) & ~cfg.async_mode;
      blank_next = (blank_reg != 16'h0) ? blank_reg - 16'h1 : 16'h0;
      if (trig) begin
         blank_next = 16'(BLANK_CYC - 1);
      end
      trig_cnt_next = trig_cnt_reg + {7'h0, trig};
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {s1_reg, s2_reg, s3_reg, trig_reg} <= 4'h0;
         blank_reg <= 16'h0;
         trig_cnt_reg <= 8'h0;
      end else begin
         s1_reg <= sync_cmp_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         trig_reg <= trig;
         blank_reg <= blank_next;
         trig_cnt_reg <= trig_cnt_next;
      end
   end
   assign trigger_time_reference_o = trig_reg;

   // ----------------------------------------
   // time base, slot choice and frame sender
   // ----------------------------------------
   logic [15:0] t_reg, t_next, slot_cyc, word_reg, word_next, w, pl;
   logic [18:0] frame_reg, frame_next;
   logic [4:0] bits_reg, bits_next, nb;
   logic [8:0] hc_reg, hc_next;
   logic [5:0] init_cnt_reg, init_cnt_next, init_lim;
   logic busy_reg, busy_next, half_reg, half_next, part_reg, part_next;
   logic sink_reg, sink_next, dis_reg, dis_next, tx_go, in_init, split, uart_line;
   logic [11:0] out_reg, out_next;
   always_comb begin
      t_next = (t_reg == 16'hffff) ? t_reg : t_reg + 16'h1;
      if (cfg.async_mode) begin
         t_next = (t_reg >= 16'(ASYNC_CYC - 1)) ? 16'h0 : t_reg + 16'h1;
      end
      if (trig) begin
         t_next = 16'h0;
      end
      unique case ({cfg.bus_par, cfg.slot_sel})
         3'b100: slot_cyc = 16'(SLOT1_CYC);
         3'b101: slot_cyc = 16'(SLOT2_CYC);
         3'b110, 3'b111: slot_cyc = 16'(SLOT3_CYC);
         default: slot_cyc = 16'(SLOT1_CYC);
      endcase
      tx_go = ~busy_reg & ~cfg.prog_en &
              (cfg.async_mode ? (t_reg == 16'h0) : (t_reg == slot_cyc));
      init_lim = cfg.init_ext ? `PSTC_INIT_LONG : `PSTC_INIT_SHORT;
      in_init = ~cfg.init_dis & (init_cnt_reg < init_lim);
      w = in_init ? {init_cnt_reg, 2'b00, cfg_reg[7:0]} : {4'h0, out_reg};
      split = cfg.proto_v13 & cfg.async_mode;
      if (cfg.proto_v13) begin
         nb = 5'd10;
         if (split) begin
            pl = part_reg ? {6'h0, 2'b01, word_reg[7:0]} : {6'h0, 2'b10, w[15:8]};
         end else begin
            pl = {6'h0, w[11:2]};
         end
      end else begin
         nb = cfg.frame16 ? 5'd16 : 5'd12;
         pl = cfg.frame16 ? w : {4'h0, w[11:0]};
      end
      frame_next = frame_reg;
      bits_next = bits_reg;
      busy_next = busy_reg;
      half_next = half_reg;
      hc_next = hc_reg;
      part_next = part_reg;
      word_next = word_reg;
      init_cnt_next = init_cnt_reg;
      if (tx_go) begin
         frame_next = {1'b0, pl, 2'b00} | (19'h1 << (nb + 5'd2)) & {19{^pl}};
         bits_next = nb + 5'd3;
         busy_next = 1'b1;
         half_next = 1'b0;
         hc_next = 9'h0;
         if (split) begin
            part_next = ~part_reg;
            word_next = part_reg ? word_reg : w;
         end
         if (in_init && (!split || part_reg)) begin
            init_cnt_next = init_cnt_reg + 6'h1;
         end
      end else if (busy_reg) begin
         hc_next = hc_reg + 9'h1;
         if (hc_reg == 9'(HALF_CYC - 1)) begin
            hc_next = 9'h0;
            half_next = ~half_reg;
            if (half_reg) begin
               frame_next = frame_reg >> 1;
               bits_next = bits_reg - 5'h1;
               busy_next = (bits_reg != 5'h1);
            end
         end
      end
      // manchester: a zero rises at mid-bit
      sink_next = busy_reg & (half_reg ? ~frame_reg[0] : frame_reg[0]);
      if (cfg.prog_en) begin
         sink_next = ~uart_line;
      end
      dis_next = cfg.dis_en & ~cfg.async_mode & (t_reg >= 16'(DIS_ON_CYC)) &
                 (t_reg < 16'(DIS_OFF_CYC));
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t_reg <= 16'hffff;
         frame_reg <= 19'h0;
         bits_reg <= 5'h0;
         {busy_reg, half_reg, part_reg, sink_reg, dis_reg} <= 5'h0;
         hc_reg <= 9'h0;
         word_reg <= 16'h0;
         init_cnt_reg <= 6'h0;
      end else begin
         t_reg <= t_next;
         frame_reg <= frame_next;
         bits_reg <= bits_next;
         busy_reg <= busy_next;
         half_reg <= half_next;
         part_reg <= part_next;
         sink_reg <= sink_next;
         dis_reg <= dis_next;
         hc_reg <= hc_next;
         word_reg <= word_next;
         init_cnt_reg <= init_cnt_next;
      end
   end
   assign current_sink_o = sink_reg;
   assign discharge_o = dis_reg;

   // ----------------------------------------
   // rotation unit and transfer function
   // ----------------------------------------
   pstc_pkg::pstc_cord_st_t cst_reg, cst_next;
   logic signed [16:0] x_reg, x_next, y_reg, y_next;
   logic [13:0] z_reg, z_next, ang_reg, ang_next, dz;
   logic [15:0] mag_reg, mag_next;
   logic [3:0] i_reg, i_next;
   logic [21:0] prod;
   function automatic logic [13:0] atan_f(input logic [3:0] i);
      unique case (i)
         4'h0: atan_f = 14'h0800;
         4'h1: atan_f = 14'h04b9;
         4'h2: atan_f = 14'h027f;
         4'h3: atan_f = 14'h0144;
         4'h4: atan_f = 14'h00a3;
         4'h5: atan_f = 14'h0051;
         4'h6: atan_f = 14'h0029;
         4'h7: atan_f = 14'h0014;
         4'h8: atan_f = 14'h000a;
         4'h9: atan_f = 14'h0005;
         4'ha: atan_f = 14'h0003;
         4'hb, 4'hc: atan_f = 14'h0001;
         default: atan_f = 14'h0000;
      endcase
   endfunction
   always_comb begin
      cst_next = cst_reg;
      {x_next, y_next, z_next, i_next} = {x_reg, y_reg, z_reg, i_reg};
      {ang_next, mag_next, out_next} = {ang_reg, mag_reg, out_reg};
      dz = 14'h0;
      prod = 22'h0;
      unique case (cst_reg)
         pstc_pkg::CORD_IDLE: begin
            if (sample_i.valid) begin
               cst_next = pstc_pkg::CORD_RUN;
               i_next = 4'h0;
               x_next = sample_i.x[13] ? -17'(sample_i.x) : 17'(sample_i.x);
               y_next = sample_i.x[13] ? -17'(sample_i.y) : 17'(sample_i.y);
               z_next = sample_i.x[13] ? 14'h2000 : 14'h0000;
            end
         end
         pstc_pkg::CORD_RUN: begin
            if (!y_reg[16]) begin
               x_next = x_reg + (y_reg >>> i_reg);
               y_next = y_reg - (x_reg >>> i_reg);
               z_next = z_reg + atan_f(i_reg);
            end else begin
               x_next = x_reg - (y_reg >>> i_reg);
               y_next = y_reg + (x_reg >>> i_reg);
               z_next = z_reg - atan_f(i_reg);
            end
            i_next = i_reg + 4'h1;
            if (i_reg == 4'hd) begin
               cst_next = pstc_pkg::CORD_IDLE;
               ang_next = z_next;
               mag_next = x_next[15:0];
               dz = z_next - cfg.zero;
               prod = dz * cfg.slope;
               if (z_next <= cfg.zero) begin
                  out_next = 12'h000;
               end else if (z_next >= cfg.stop || prod[21:16] != 6'h0) begin
                  out_next = 12'hfff;
               end else begin
                  out_next = prod[15:4];
               end
            end
         end
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cst_reg <= pstc_pkg::CORD_IDLE;
         {x_reg, y_reg} <= 34'h0;
         {z_reg, ang_reg} <= 28'h0;
         i_reg <= 4'h0;
         mag_reg <= 16'h0;
         out_reg <= 12'h0;
      end else begin
         cst_reg <= cst_next;
         x_reg <= x_next;
         y_reg <= y_next;
         z_reg <= z_next;
         i_reg <= i_next;
         ang_reg <= ang_next;
         mag_reg <= mag_next;
         out_reg <= out_next;
      end
   end
   assign out_code_o = out_reg;

   // ----------------------------------------
   // serial programming port on the supply pin
   // ----------------------------------------
   pstc_pkg::pstc_rx_st_t rx_reg, rx_next;
   logic r1_reg, r2_reg, have_reg, have_next, prog_wr, prog_rd;
   logic [9:0] rc_reg, rc_next, tc_reg, tc_next, tsh_reg, tsh_next;
   logic [2:0] rb_reg, rb_next;
   logic [7:0] sh_reg, sh_next, cmd_reg, cmd_next, rd_val;
   logic [3:0] tl_reg, tl_next;
   always_comb begin
      {rx_next, rc_next, rb_next, sh_next} = {rx_reg, rc_reg + 10'h1, rb_reg, sh_reg};
      {have_next, cmd_next, prog_wr, prog_rd} = {have_reg, cmd_reg, 2'b00};
      unique case (rx_reg)
         pstc_pkg::RX_IDLE: begin
            rc_next = 10'h0;
            if (!r2_reg) rx_next = pstc_pkg::RX_START;
         end
         pstc_pkg::RX_START: if (rc_reg == 10'(UART_CYC / 2 - 1)) begin
            rc_next = 10'h0;
            rb_next = 3'h0;
            rx_next = r2_reg ? pstc_pkg::RX_IDLE : pstc_pkg::RX_DATA;
         end
         pstc_pkg::RX_DATA: if (rc_reg == 10'(UART_CYC - 1)) begin
            rc_next = 10'h0;
            sh_next = {r2_reg, sh_reg[7:1]};
            rb_next = rb_reg + 3'h1;
            if (rb_reg == 3'h7) rx_next = pstc_pkg::RX_STOP;
         end
         pstc_pkg::RX_STOP: if (rc_reg == 10'(UART_CYC - 1)) begin
            rx_next = pstc_pkg::RX_IDLE;
            if (r2_reg && cfg.prog_en) begin
               if (have_reg) begin
                  prog_wr = 1'b1;
                  have_next = 1'b0;
               end else if (sh_reg[7]) begin
                  prog_rd = 1'b1;
               end else begin
                  have_next = 1'b1;
                  cmd_next = sh_reg;
               end
            end
         end
      endcase
      unique case (sh_reg[1:0])
         2'h0: rd_val = ang_reg[7:0];
         2'h1: rd_val = {2'b00, ang_reg[13:8]};
         2'h2: rd_val = mag_reg[15:8];
         2'h3: rd_val = gain_control_value_i;
      endcase
      {tsh_next, tl_next, tc_next} = {tsh_reg, tl_reg, tc_reg + 10'h1};
      if (prog_rd) begin
         {tsh_next, tl_next, tc_next} = {1'b1, rd_val, 1'b0, 4'd10, 10'h0};
      end else if (tl_reg == 4'h0) begin
         tc_next = 10'h0;
      end else if (tc_reg == 10'(UART_CYC - 1)) begin
         {tsh_next, tl_next, tc_next} = {1'b1, tsh_reg[9:1], tl_reg - 4'h1, 10'h0};
      end
      uart_line = (tl_reg == 4'h0) | tsh_reg[0];
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_reg <= pstc_pkg::RX_IDLE;
         {r1_reg, r2_reg, have_reg} <= 3'b110;
         {rc_reg, tc_reg, tsh_reg} <= 30'h0;
         {rb_reg, tl_reg} <= 7'h0;
         {sh_reg, cmd_reg} <= 16'h0;
      end else begin
         r1_reg <= prog_rx_i;
         r2_reg <= r1_reg;
         rx_reg <= rx_next;
         rc_reg <= rc_next;
         rb_reg <= rb_next;
         sh_reg <= sh_next;
         have_reg <= have_next;
         cmd_reg <= cmd_next;
         tsh_reg <= tsh_next;
         tl_reg <= tl_next;
         tc_reg <= tc_next;
      end
   end

   // ----------------------------------------
   // wishbone registers and config store
   // ----------------------------------------
   logic ack_next, wr;
   logic [31:0] dat_next;
   always_comb begin
      ack_next = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wr = ack_next & wb_we_i;
      cfg_next = cfg_reg;
      for (int b = 0; b < 8; b++) begin
         if (wr && wb_sel_i[b % 4] && wb_adr_i == ((b < 4) ? `PSTC_ADR_CFG0 : `PSTC_ADR_CFG1))
         begin
            cfg_next[b * 8 +: 8] = wb_dat_i[(b % 4) * 8 +: 8];
         end
      end
      if (prog_wr) begin
         // one-time store: bits can only be set
         cfg_next[{cmd_reg[2:0], 3'b000} +: 8] = cfg_next[{cmd_reg[2:0], 3'b000} +: 8] | sh_reg;
      end
      unique case (wb_adr_i)
         `PSTC_ADR_CFG0: dat_next = cfg_reg[31:0];
         `PSTC_ADR_CFG1: dat_next = cfg_reg[63:32];
         `PSTC_ADR_STAT: dat_next = {8'h0, trig_cnt_reg, 2'b00, init_cnt_reg, 3'b000,
                                     cst_reg == pstc_pkg::CORD_RUN, busy_reg, part_reg,
                                     blank_reg != 16'h0, s2_reg};
         `PSTC_ADR_MEAS: dat_next = {mag_reg, 2'b00, ang_reg};
         `PSTC_ADR_OUT: dat_next = {12'h0, gain_control_value_i, out_reg};
         default: dat_next = 32'h0;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_reg <= `PSTC_CFG_RST;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         cfg_reg <= cfg_next;
         wb_ack_o <= ack_next;
         wb_dat_o <= dat_next;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [15:0] gap_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) gap_reg <= 16'hffff;
      else gap_reg <= trig_reg ? 16'h1 : ((gap_reg == 16'hffff) ? gap_reg : gap_reg + 16'h1);
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_run8;
      cst_reg == pstc_pkg::CORD_RUN [*8];
   endsequence
   sequence s_run6;
      cst_reg == pstc_pkg::CORD_RUN [*6];
   endsequence
   property p_blank;
      trig_reg |-> gap_reg >= 16'(BLANK_CYC);
   endproperty
   a_blank: assert property (p_blank) else $error("retrigger inside blank");
   property p_edge;
      trig_reg |-> s3_reg && !$past(s3_reg);
   endproperty
   a_edge: assert property (p_edge) else $error("trigger without edge");
   property p_ref;
      trig_reg |-> t_reg == 16'h0;
   endproperty
   a_ref: assert property (p_ref) else $error("time base not zeroed");
   property p_slot;
      $rose(busy_reg) && !cfg.async_mode |-> t_reg == slot_cyc + 16'h1;
   endproperty
   a_slot: assert property (p_slot) else $error("frame outside slot");
   property p_async;
      $rose(busy_reg) && cfg.async_mode |-> t_reg == 16'h1;
   endproperty
   a_async: assert property (p_async) else $error("async frame off period");
   property p_split;
      $rose(busy_reg) && cfg.async_mode && cfg.proto_v13 |-> part_reg != $past(part_reg);
   endproperty
   a_split: assert property (p_split) else $error("word not split");
   property p_init;
      $changed(init_cnt_reg) |-> $past(init_cnt_reg) < init_lim;
   endproperty
   a_init: assert property (p_init) else $error("too many init blocks");
   property p_dis;
      discharge_o |-> cfg.dis_en && t_reg > 16'(DIS_ON_CYC) && t_reg <= 16'(DIS_OFF_CYC);
   endproperty
   a_dis: assert property (p_dis) else $error("discharge outside window");
   property p_manch;
      $rose(half_reg) && busy_reg && !cfg.prog_en |=> $changed(current_sink_o);
   endproperty
   a_manch: assert property (p_manch) else $error("no mid-bit transition");
   property p_cord;
      cst_reg == pstc_pkg::CORD_IDLE && sample_i.valid |=>
         s_run8 ##1 s_run6 ##1 cst_reg == pstc_pkg::CORD_IDLE;
   endproperty
   a_cord: assert property (p_cord) else $error("rotation unit length");
   property p_xfer;
      $fell(cst_reg == pstc_pkg::CORD_RUN) && ang_reg <= cfg.zero |-> out_reg == 12'h0;
   endproperty
   a_xfer: assert property (p_xfer) else $error("below zero angle not zero");
   property p_rd;
      prog_rd |=> tl_reg == 4'd10 ##1 current_sink_o;
   endproperty
   a_rd: assert property (p_rd) else $error("read reply missing");
   property p_wr;
      prog_wr |=> (cfg_reg[{$past(cmd_reg[2:0]), 3'b000} +: 8] & $past(sh_reg)) == $past(sh_reg);
   endproperty
   a_wr: assert property (p_wr) else $error("programmed bits missing");
endmodule // pstc_sync_slot
`default_nettype wire

// *** verification/pstc_ecu_model.sv ***
// ecu side model: sync pulses on the comparator line, idle serial line
// assumes the bench calls sync_pulse from its own sequence
`timescale 1ns/1ps
`default_nettype none
module pstc_ecu_model (
   // clock
   input wire logic clk_i,
   // supply pin view
   output logic sync_cmp_o,
   output logic prog_rx_o
);
   initial begin
      sync_cmp_o = 1'b0;
      prog_rx_o = 1'b1;
   end
   // supply raised above the trigger threshold for len cycles
   task automatic sync_pulse(input int len);
      @(posedge clk_i);
      sync_cmp_o <= 1'b1;
      repeat (len) @(posedge clk_i);
      sync_cmp_o <= 1'b0;
   endtask
endmodule // pstc_ecu_model
`default_nettype wire

// *** verification/psi5_sync_trigger_and_slot_control_tb.sv ***
// self-checking bench of the sync/slot block
// assumes the ecu model drives the comparator and serial lines
`timescale 1ns/1ps
`default_nettype none
module psi5_sync_trigger_and_slot_control_tb;
   logic clk_i, rst_i, cyc, stb, we, ack, sink, dis, trig;
   logic [7:0] adr;
   logic [31:0] wdat, rdat;
   logic [11:0] code;
   logic sync_cmp, prog_rx;
   logic [3:0] sel;
   logic [7:0] gain;
   pstc_pkg::pstc_sample_t smp;
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc_cnt = 0;
   pstc_ecu_model u_ecu (.clk_i(clk_i), .sync_cmp_o(sync_cmp), .prog_rx_o(prog_rx));
   pstc_sync_slot #(.BLANK_CYC(200), .SLOT1_CYC(300), .SLOT2_CYC(500), .SLOT3_CYC(700))
      u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sync_cmp_i(sync_cmp),
      .prog_rx_i(prog_rx), .current_sink_o(sink), .discharge_o(dis),
      .trigger_time_reference_o(trig), .sample_i(smp), .gain_control_value_i(gain),
      .out_code_o(code));
   initial clk_i = 1'b0;
   always #5 clk_i = ~clk_i;
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 90000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      {cyc, stb, we} <= 3'b000;
      @(posedge clk_i);
   endtask
   task automatic wait_trig(input int lim, output int d);
      d = 0;
      while (trig !== 1'b1 && d < lim) begin
         @(posedge clk_i);
         d++;
      end
   endtask
   // pulse and wait for the trigger at once
   task automatic pulse_trig(input int lim, output int d);
      fork
         u_ecu.sync_pulse(10);
         wait_trig(lim, d);
      join
   endtask
   task automatic t_regs();
      logic [31:0] q;
      wb(1'b0, 8'h00, 32'h0, q);
      check(q, 32'h0);
      wb(1'b0, 8'h04, 32'h0, q);
      check(q, 32'h0004_3fff);
      sel <= 4'h1;
      wb(1'b1, 8'h04, 32'hffff_ff12, q);
      sel <= 4'hf;
      wb(1'b0, 8'h04, 32'h0, q);
      check(q, 32'h0004_3f12);
      wb(1'b1, 8'h04, 32'h0004_3fff, q);
      wb(1'b0, 8'h20, 32'h0, q);
      check(q, 32'h0);
      $display("register test done");
   endtask
   task automatic t_blank();
      int d;
      pulse_trig(20, d);
      check(d < 20, 1'b1);
      pulse_trig(150, d);
      check(d, 150);
      repeat (60) @(posedge clk_i);
      pulse_trig(20, d);
      check(d < 20, 1'b1);
      repeat (16500) @(posedge clk_i);
      $display("blanking test done");
   endtask
   task automatic t_slot(input logic [31:0] c, input int exp, input int exp_dis);
      int d;
      int nd;
      logic [31:0] q;
      wb(1'b1, 8'h00, c, q);
      wb(1'b0, 8'h00, 32'h0, q);
      check(q, c);
      pulse_trig(20, d);
      check(d < 20, 1'b1);
      d = 0;
      nd = 0;
      while (sink !== 1'b1 && d < exp + 50) begin
         @(posedge clk_i);
         d++;
         nd += int'(dis === 1'b1);
      end
      check(d >= exp - 4 && d <= exp + 4, 1'b1);
      repeat (16500) begin
         @(posedge clk_i);
         nd += int'(dis === 1'b1);
      end
      check(nd, exp_dis);
      $display("slot test done");
   endtask
   // one sample at 90 degrees, then the transfer function against zero and stop
   task automatic t_angle(input logic [31:0] c0, input logic [31:0] c1, input logic [11:0] e);
      logic [31:0] q;
      wb(1'b1, 8'h00, c0, q);
      wb(1'b1, 8'h04, c1, q);
      smp <= {1'b1, 14'h0000, 14'h1000};
      @(posedge clk_i);
      smp.valid <= 1'b0;
      repeat (20) @(posedge clk_i);
      check(code, e);
      wb(1'b0, 8'h10, 32'h0, q);
      check(q, {12'h0, 8'h5a, e});
      wb(1'b0, 8'h0c, 32'h0, q);
      check(q[13:0] >= 14'd4080 && q[13:0] <= 14'd4112, 1'b1);
      check(q[31:16] >= 16'd6705 && q[31:16] <= 16'd6785, 1'b1);
      $display("angle test done");
   endtask
   task automatic t_async();
      int d;
      logic [31:0] q;
      wb(1'b1, 8'h00, 32'h1, q);
      pulse_trig(40, d);
      check(d, 40);
      $display("async test done");
   endtask
   initial begin
      {rst_i, cyc, stb, we, adr, wdat} = {1'b1, 3'b000, 8'h00, 32'h0};
      {sel, smp, gain} = {4'hf, 29'h0, 8'h5a};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_blank();
      t_slot(32'h0000_0100, 700, 2050);
      t_slot(32'h0000_0006, 900, 0);
      t_angle(32'h3000_0000, 32'h0004_3fff, 12'h000);
      t_angle(32'h0000_0000, 32'h0004_0800, 12'hfff);
      t_async();
      stop_test();
   end
endmodule // psi5_sync_trigger_and_slot_control_tb
`default_nettype wire
